/* rtl/fault_response_manager.sv */
// Fault response manager: bridge state, logic enable, reporting and recovery.
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/100ps
module fault_response_manager
  import fault_response_pkg::*;
#(
  parameter int OC_RETRY_CYC = fault_response_pkg::OC_RETRY_CYCLES,
  parameter int STALL_RETRY_CYC = fault_response_pkg::STALL_RETRY_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog monitor levels, asynchronous
  input wire logic vm_low,
  input wire logic avdd_low,
  input wire logic stepdown_low,
  input wire logic pump_low,
  input wire logic vm_over,
  input wire logic phase_overcurrent,
  input wire logic stepdown_overcurrent,
  input wire logic speed_abnormal,
  input wire logic no_motor,
  input wire logic sync_lost,
  // Commutation requests from the drive logic
  input wire logic [2:0] drive_hs,
  input wire logic [2:0] drive_ls,
  input wire logic hs_modulation,
  // Power stage and status outputs
  output logic [2:0] gate_hs,
  output logic [2:0] gate_ls,
  output logic logic_active,
  output logic supply_low_reset,
  output logic fault_indicator_n
);

  import fault_response_pkg::*;

  // Synchronised monitor levels.
  logic [9:0] mon_s;
  logic vm_low_s;
  logic avdd_low_s;
  logic stepdown_low_s;
  logic pump_low_s;
  logic vm_over_s;
  logic phase_oc_s;
  logic stepdown_oc_s;
  logic speed_s;
  logic no_motor_s;
  logic sync_lost_s;

  signal_sync #(.WIDTH(10)) u_sync (
    .clock(clock),
    .rst(rst),
    .async_in({vm_low, avdd_low, stepdown_low, pump_low, vm_over,
      phase_overcurrent, stepdown_overcurrent, speed_abnormal, no_motor,
      sync_lost}),
    .sync_out(mon_s)
  );

  assign {vm_low_s, avdd_low_s, stepdown_low_s, pump_low_s, vm_over_s,
    phase_oc_s, stepdown_oc_s, speed_s, no_motor_s, sync_lost_s} = mon_s;

  // Registers.
  logic [CFG_WIDTH-1:0] cfg_q;
  logic [CFG_WIDTH-1:0] cfg_d;
  logic [2:0] drv_flags_q;
  logic [2:0] drv_flags_d;
  logic [3:0] ctl_flags_q;
  logic [3:0] ctl_flags_d;
  logic oc_latch_q;
  logic oc_latch_d;
  logic oc_retry_q;
  logic oc_retry_d;
  logic sd_retry_q;
  logic sd_retry_d;
  logic st_latch_q;
  logic st_latch_d;
  logic st_retry_q;
  logic st_retry_d;
  logic [1:0] st_act_q;
  logic [1:0] st_act_d;
  logic rec_armed_q;
  logic rec_done_q;
  logic rec_done_d;
  logic [2:0] rec_hs_q;
  logic [2:0] rec_ls_q;
  logic [2:0] gate_hs_q;
  logic [2:0] gate_hs_d;
  logic [2:0] gate_ls_q;
  logic [2:0] gate_ls_d;
  bridge_type bridge_q;
  logic logic_q;
  logic logic_d;
  logic supply_q;
  logic pin_n_q;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pready_q;
  logic pslverr_q;

  // Configuration fields.
  logic ovg_on;
  logic [1:0] ocp_pol;
  logic [3:0] stall_pol;
  assign ovg_on = cfg_q[CFG_OVG_BIT];
  assign ocp_pol = cfg_q[CFG_OCP_LSB +: 2];
  assign stall_pol = cfg_q[CFG_STALL_LSB +: 4];

  // APB decode; the access phase always completes in its first cycle.
  logic setup;
  logic wr_done;
  logic hit_cfg;
  logic hit_ctl;
  logic hit_drv;
  logic hit_cfl;
  logic hit_sts;
  logic mapped;
  logic clr;
  logic [31:0] rd_mux;
  assign setup = psel & ~penable;
  assign wr_done = psel & penable & pready_q & pwrite & ~pslverr_q;
  assign hit_cfg = paddr == ADDR_CONFIG;
  assign hit_ctl = paddr == ADDR_CONTROL;
  assign hit_drv = paddr == ADDR_DRIVER_FLAGS;
  assign hit_cfl = paddr == ADDR_CONTROL_FLAGS;
  assign hit_sts = paddr == ADDR_STATUS;
  assign mapped = hit_cfg | hit_ctl | hit_drv | hit_cfl | hit_sts;
  assign clr = wr_done & hit_ctl & pstrb[0] & pwdata[CTL_CLEAR_BIT];
  assign cfg_d = (wr_done & hit_cfg & pstrb[0]) ? pwdata[CFG_WIDTH-1:0]
    : cfg_q;
  assign rd_mux = hit_cfg ? {25'h0, cfg_q}
    : hit_drv ? {29'h0, drv_flags_q}
    : hit_cfl ? {28'h0, ctl_flags_q}
    : hit_sts ? {26'h0, supply_q, ~pin_n_q, logic_q, bridge_q}
    : 32'h0;
  assign prdata_d = (setup & ~pwrite) ? rd_mux : prdata_q;

  // Fault conditions and their configured treatment.
  logic uv_any;
  logic ov_act;
  logic stall_s;
  logic oc_report;
  logic oc_flag;
  logic st_report;
  logic st_flag;
  assign uv_any = vm_low_s | avdd_low_s | stepdown_low_s;
  assign ov_act = vm_over_s & ovg_on;
  assign stall_s = speed_s | no_motor_s | sync_lost_s;
  assign oc_report = ocp_pol == OCP_LATCH || ocp_pol == OCP_RETRY;
  assign oc_flag = oc_report || ocp_pol == OCP_FLAG;
  assign st_report = ~stall_pol[3];
  assign st_flag = st_report | (stall_pol == STALL_FLAG_ONLY);

  // Phase and stepdown overcurrent recovery; a set always beats a clear.
  logic oc_retry_set;
  logic sd_retry_set;
  logic oc_tmr_busy;
  logic oc_tmr_done;
  assign oc_latch_d = (oc_latch_q & ~clr)
    | (phase_oc_s & ocp_pol == OCP_LATCH);
  assign oc_retry_set = phase_oc_s & ocp_pol == OCP_RETRY & ~oc_retry_q;
  assign oc_retry_d = (oc_retry_q & ~oc_tmr_done) | oc_retry_set;
  assign sd_retry_set = stepdown_oc_s & ~sd_retry_q;
  assign sd_retry_d = (sd_retry_q & ~oc_tmr_done) | sd_retry_set;

  // Both overcurrent retries share one timer; a late joiner ends early.
  retry_timer #(.WIDTH(TIMER_WIDTH), .CYCLES(OC_RETRY_CYC)) u_oc_timer (
    .clock(clock),
    .rst(rst),
    .start((oc_retry_set | sd_retry_set) & ~oc_tmr_busy),
    .busy(oc_tmr_busy),
    .done(oc_tmr_done)
  );

  // Stall recovery; the action is frozen when the fault is taken.
  logic st_latch_set;
  logic st_retry_set;
  logic st_tmr_done;
  assign st_latch_set = stall_s & st_report & ~stall_pol[2];
  assign st_latch_d = (st_latch_q & ~clr) | st_latch_set;
  assign st_retry_set = stall_s & st_report & stall_pol[2]
    & ~st_retry_q;
  assign st_retry_d = (st_retry_q & ~st_tmr_done) | st_retry_set;
  assign st_act_d = ((st_latch_set & ~st_latch_q) | st_retry_set)
    ? stall_pol[1:0] : st_act_q;

  retry_timer #(.WIDTH(TIMER_WIDTH), .CYCLES(STALL_RETRY_CYC)) u_st_timer (
    .clock(clock),
    .rst(rst),
    .start(st_retry_set),
    .busy(),
    .done(st_tmr_done)
  );

  // Sticky flags: a new detection beats a clear in the same cycle.
  assign drv_flags_d = (drv_flags_q & ~{3{clr}})
    | {phase_oc_s & oc_flag, ov_act, pump_low_s};
  assign ctl_flags_d = (ctl_flags_q & ~{4{clr}})
    | ({sync_lost_s, no_motor_s, speed_s, stall_s}
      & {4{st_flag}});

  // Pin stays asserted while any reported fault is unrecovered.
  logic pending;
  assign pending = pump_low_s | ov_act | oc_latch_q | oc_retry_q
    | st_latch_q | st_retry_q | (phase_oc_s & oc_report)
    | (stall_s & st_report);

  // Bridge state selection: the most restrictive demand wins.
  logic hiz_need;
  bridge_type stall_state;
  bridge_type demand;
  bridge_type eff_state;
  assign hiz_need = uv_any | pump_low_s | ov_act | oc_latch_q | oc_retry_q
    | sd_retry_q;
  assign stall_state = (st_latch_q | st_retry_q) ? stall_action(st_act_q)
    : BR_ACTIVE;
  assign demand = bridge_max(stall_state,
    hiz_need ? BR_HIZ : BR_ACTIVE);
  assign eff_state = (demand == BR_RECIRC && rec_done_q) ? BR_HIZ
    : demand;
  assign logic_d = ~(uv_any | sd_retry_q);

  // Recirculation keeps only the switches on the unmodulated side.
  logic rec_want;
  logic rec_start;
  logic rec_tmr_done;
  assign rec_want = demand == BR_RECIRC;
  assign rec_start = rec_want & ~rec_armed_q;
  assign rec_done_d = rec_want & (rec_done_q | rec_tmr_done);

  retry_timer #(.WIDTH(TIMER_WIDTH), .CYCLES(RECIRC_DECAY_CYCLES)) u_rec (
    .clock(clock),
    .rst(rst),
    .start(rec_start),
    .busy(),
    .done(rec_tmr_done)
  );

  assign gate_hs_d = eff_state == BR_ACTIVE ? drive_hs
    : eff_state == BR_HS_BRAKE ? 3'h7
    : eff_state == BR_RECIRC ? rec_hs_q
    : 3'h0;
  assign gate_ls_d = eff_state == BR_ACTIVE ? drive_ls
    : eff_state == BR_LS_BRAKE ? 3'h7
    : eff_state == BR_RECIRC ? rec_ls_q
    : 3'h0;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cfg_q <= CONFIG_RESET;
      drv_flags_q <= FLAGS3_RESET;
      ctl_flags_q <= FLAGS4_RESET;
      oc_latch_q <= 1'b0;
      oc_retry_q <= 1'b0;
      sd_retry_q <= 1'b0;
      st_latch_q <= 1'b0;
      st_retry_q <= 1'b0;
      st_act_q <= 2'h0;
    end else begin
      cfg_q <= cfg_d;
      drv_flags_q <= drv_flags_d;
      ctl_flags_q <= ctl_flags_d;
      oc_latch_q <= oc_latch_d;
      oc_retry_q <= oc_retry_d;
      sd_retry_q <= sd_retry_d;
      st_latch_q <= st_latch_d;
      st_retry_q <= st_retry_d;
      st_act_q <= st_act_d;
    end
  end

  // The captured pattern follows hs_modulation at recirculation entry.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rec_armed_q <= 1'b0;
      rec_done_q <= 1'b0;
      rec_hs_q <= 3'h0;
      rec_ls_q <= 3'h0;
    end else begin
      rec_armed_q <= rec_want;
      rec_done_q <= rec_done_d;
      if (rec_start) begin
        rec_hs_q <= hs_modulation ? 3'h0 : drive_hs;
        rec_ls_q <= hs_modulation ? drive_ls : 3'h0;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      gate_hs_q <= 3'h0;
      gate_ls_q <= 3'h0;
      bridge_q <= BR_HIZ;
      logic_q <= 1'b0;
      supply_q <= 1'b0;
      pin_n_q <= 1'b1;
    end else begin
      gate_hs_q <= gate_hs_d;
      gate_ls_q <= gate_ls_d;
      bridge_q <= eff_state;
      logic_q <= logic_d;
      supply_q <= vm_low_s | avdd_low_s;
      pin_n_q <= ~pending;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prdata_q <= 32'h0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      pready_q <= setup;
      pslverr_q <= setup & ~mapped;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign gate_hs = gate_hs_q;
  assign gate_ls = gate_ls_q;
  assign logic_active = logic_q;
  assign supply_low_reset = supply_q;
  assign fault_indicator_n = pin_n_q;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  a_uv_hiz_off: assert property (
    uv_any |=> gate_hs_q == 3'h0 && gate_ls_q == 3'h0 && !logic_q)
    else $error("undervoltage did not force Hi-Z with logic off");
  a_pump_report: assert property (
    pump_low_s |=> !pin_n_q && drv_flags_q[0] && bridge_q == BR_HIZ)
    else $error("pump undervoltage not reported or not Hi-Z");
  a_ov_guarded: assert property (
    vm_over_s && ovg_on |=> !pin_n_q && drv_flags_q[1] && gate_hs_q == 3'h0)
    else $error("enabled overvoltage not handled");
  a_oc_latch_hold: assert property (
    oc_latch_q && !clr |=> oc_latch_q)
    else $error("phase overcurrent latch released without clear");
  a_sd_retry_off: assert property (
    $rose(sd_retry_q) |=> !logic_q ##1 !logic_q)
    else $error("regulator overcurrent left logic enabled");
  a_stall_latch: assert property (
    stall_s && stall_pol == 4'h3 && !st_latch_q && !st_retry_q
      |=> st_latch_q && st_act_q == 2'h3)
    else $error("stall did not latch low-side brake");
  a_stall_retry: assert property (
    stall_s && stall_pol == 4'h5 && !st_retry_q
      |=> st_retry_q && stall_state == BR_RECIRC)
    else $error("stall retry not started");
  a_stall_flag: assert property (
    stall_s && stall_pol == STALL_FLAG_ONLY && !st_latch_q && !st_retry_q
      |=> ctl_flags_q[0] && !st_latch_q && !st_retry_q)
    else $error("flag-only stall took action");
  a_sync_source: assert property (
    $rose(sync_lost_s) && !stall_pol[3]
      |=> ctl_flags_q[3] && ctl_flags_q[0] && !pin_n_q)
    else $error("loss of sync did not raise stall");
  a_recirc_end: assert property (
    rec_done_q && demand == BR_RECIRC |=> gate_hs_q == 3'h0
      && gate_ls_q == 3'h0)
    else $error("recirculation did not end in Hi-Z");
  a_brake_all: assert property (
    eff_state == BR_LS_BRAKE |=> gate_ls_q == 3'h7 && gate_hs_q == 3'h0)
    else $error("low-side brake pattern wrong");
  a_pin_hold: assert property (
    st_latch_q |=> !pin_n_q)
    else $error("pin released while stall latched");
  a_clear_release: assert property (
    clr && !phase_oc_s && !stall_s |=> !oc_latch_q && !st_latch_q
      && drv_flags_q[2] == 1'b0)
    else $error("clear did not release latched faults");

  c_oc_retry_done: cover property (oc_retry_q ##1 !oc_retry_q);
  c_recirc_decay: cover property ($rose(rec_done_q));
  c_clear_stall: cover property (st_latch_q && clr);

endmodule

/* rtl/fault_response_pkg.sv */
// Shared constants, types and helper functions of the fault response manager.
package fault_response_pkg;

  // Clock rate and fault timing; each time is kept in its own unit.
  localparam int CLOCK_KHZ = 40000;
  localparam int OC_RETRY_US = 5000;
  localparam int STALL_RETRY_MS = 1000;
  localparam int RECIRC_DECAY_US = 50;
  localparam int OC_RETRY_CYCLES = (OC_RETRY_US * CLOCK_KHZ + 999) / 1000;
  localparam int STALL_RETRY_CYCLES = STALL_RETRY_MS * CLOCK_KHZ;
  localparam int RECIRC_DECAY_CYCLES =
    (RECIRC_DECAY_US * CLOCK_KHZ + 999) / 1000;
  localparam int TIMER_WIDTH = 26;

  // Register byte addresses.
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_CONTROL = 8'h04;
  localparam logic [7:0] ADDR_DRIVER_FLAGS = 8'h08;
  localparam logic [7:0] ADDR_CONTROL_FLAGS = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  // Field layout and reset values.
  localparam int CFG_WIDTH = 7;
  localparam int CFG_OVG_BIT = 0;
  localparam int CFG_OCP_LSB = 1;
  localparam int CFG_STALL_LSB = 3;
  localparam logic [6:0] CONFIG_RESET = 7'h00;
  localparam int CTL_CLEAR_BIT = 0;
  localparam logic [2:0] FLAGS3_RESET = 3'h0;
  localparam logic [3:0] FLAGS4_RESET = 4'h0;

  // Policy encodings.
  localparam logic [1:0] OCP_LATCH = 2'h0;
  localparam logic [1:0] OCP_RETRY = 2'h1;
  localparam logic [1:0] OCP_FLAG = 2'h2;
  localparam logic [3:0] STALL_FLAG_ONLY = 4'h8;

  // Bridge states, numbered so that a larger code is more restrictive.
  typedef enum logic [2:0] {
    BR_ACTIVE = 3'b000,
    BR_HS_BRAKE = 3'b001,
    BR_LS_BRAKE = 3'b010,
    BR_RECIRC = 3'b011,
    BR_HIZ = 3'b100
  } bridge_type;

  function automatic bridge_type bridge_max(bridge_type a, bridge_type b);
    return (a > b) ? a : b;
  endfunction

  function automatic bridge_type stall_action(logic [1:0] code);
    bridge_type r;
    r = BR_HIZ;
    unique case (code)
      2'h0: r = BR_HIZ;
      2'h1: r = BR_RECIRC;
      2'h2: r = BR_HS_BRAKE;
      2'h3: r = BR_LS_BRAKE;
    endcase
    return r;
  endfunction

endpackage

/* rtl/retry_timer.sv */
// One-shot down counter that pulses done a fixed number of cycles after start.
`timescale 1ns/100ps
module retry_timer #(
  parameter int WIDTH = 26,
  parameter int CYCLES = 2000
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Control
  input wire logic start,
  output logic busy,
  output logic done
);

  localparam logic [WIDTH-1:0] LOAD = WIDTH'(CYCLES - 1);

  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;
  logic busy_q;
  logic busy_d;
  logic done_q;
  logic done_d;
  logic launch;

  // A start always reloads, so a new wait never inherits the tail of an
  // abandoned one; a caller that must not stretch a running wait gates start
  // with busy.
  assign launch = start;
  assign count_d = launch ? LOAD : (busy_q ? count_q - 1'b1 : count_q);
  assign busy_d = launch | (busy_q & (count_q != '0));
  assign done_d = busy_q & (count_q == '0) & ~launch;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      count_q <= count_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign busy = busy_q;
  assign done = done_q;

endmodule

/* rtl/signal_sync.sv */
// Two-stage synchroniser for a vector of asynchronous monitor levels.
`timescale 1ns/100ps
module signal_sync #(
  parameter int WIDTH = 10
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_q;
  logic [WIDTH-1:0] stage2_q;

  // The first stage feeds only the second one.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stage1_q <= '0;
      stage2_q <= '0;
    end else begin
      stage1_q <= async_in;
      stage2_q <= stage1_q;
    end
  end

  assign sync_out = stage2_q;

endmodule

/* tb/monitor_model.sv */
// Far-side model: analog fault comparators and a watch on the power stage.
`timescale 1ns/100ps
module monitor_model (
  // Clock
  input wire logic clock,
  // Comparator states requested by the bench
  input wire logic [9:0] level_req,
  // Switch commands seen at the power stage
  input wire logic [2:0] gate_hs,
  input wire logic [2:0] gate_ls,
  // Comparator outputs and bridge watch
  output logic [9:0] levels,
  output logic shoot_through
);
  // A comparator output only moves after the request is seen at an edge.
  initial levels = 10'h000;
  always @(posedge clock) begin
    levels <= level_req;
  end
  // Both switches of one phase on would short the supply.
  assign shoot_through = |(gate_hs & gate_ls);
endmodule

/* tb/tb_top.sv */
// Testbench of the fault response manager, driven over APB.
`timescale 1ns/100ps
module tb_top;
  import fault_response_pkg::*;
  localparam logic [5:0] G_RUN = 6'h0c;
  localparam logic [5:0] G_HIZ = 6'h00;
  localparam logic [5:0] G_REC = 6'h04;
  logic clock, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [9:0] level_req, levels;
  logic [2:0] drive_hs, drive_ls, gate_hs, gate_ls;
  logic hs_modulation, logic_active, supply_low_reset, fault_indicator_n;
  logic shoot_through;
  int fails, checks, cycles;

  fault_response_manager #(.OC_RETRY_CYC(20), .STALL_RETRY_CYC(30))
      fault_response_manager_i (
    .clock(clock), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .vm_low(levels[0]), .avdd_low(levels[1]), .stepdown_low(levels[2]),
    .pump_low(levels[3]), .vm_over(levels[4]),
    .phase_overcurrent(levels[5]), .stepdown_overcurrent(levels[6]),
    .speed_abnormal(levels[7]), .no_motor(levels[8]), .sync_lost(levels[9]),
    .drive_hs(drive_hs), .drive_ls(drive_ls), .hs_modulation(hs_modulation),
    .gate_hs(gate_hs), .gate_ls(gate_ls), .logic_active(logic_active),
    .supply_low_reset(supply_low_reset),
    .fault_indicator_n(fault_indicator_n));

  monitor_model monitor_model_i (
    .clock(clock), .level_req(level_req), .gate_hs(gate_hs),
    .gate_ls(gate_ls), .levels(levels), .shoot_through(shoot_through));

  initial begin
    clock = 1'h0;
    forever #12.5 clock = ~clock;
  end

  task automatic wrap_up();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // The whole run needs about 3900 cycles; 10000 means a hang.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      fails = fails + 1;
      $display("wrong value at %0t: run timed out", $time);
      wrap_up();
    end
  end

  always @(negedge clock) begin
    if (shoot_through === 1'h1) begin
      fails = fails + 1;
      $display("wrong value at %0t: both switches of a phase on", $time);
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
      input string what);
    checks = checks + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what,
               seen, exp);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  // Request is held until pready is seen high at a rising edge.
  task automatic apb(input logic [7:0] a, input logic wr,
      input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge clock);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    do @(posedge clock); while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'h1, d, rd, err);
  endtask

  task automatic rd_check(input logic [7:0] a, input logic [31:0] x,
      input string w);
    apb(a, 1'h0, 32'h0, rd, err);
    check(rd, x, w);
  endtask

  task automatic outs(input logic [7:0] x, input string w);
    check({24'h0, gate_hs, gate_ls, logic_active, fault_indicator_n},
          {24'h0, x}, w);
  endtask

  // Holds one comparator for 13 cycles (ten, then a three-cycle flag read), then checks the recovery.
  task automatic fault_case(input int idx, input logic [7:0] during,
      input logic [7:0] after, input logic [7:0] fa, input logic [31:0] fx);
    level_req[idx] <= 1'h1;
    wait_cyc(10);
    outs(during, "outputs during fault");
    check({31'h0, supply_low_reset}, {31'h0, idx < 2},
          "supply low output");
    rd_check(fa, fx, "flags during fault");
    level_req[idx] <= 1'h0;
    wait_cyc(60);
    outs(after, "outputs after fault");
  endtask

  task automatic clear_all();
    wr(ADDR_CONTROL, 32'h1);
    wait_cyc(8);
  endtask

  function automatic logic [5:0] stall_gates(input int m);
    case (m % 4)
      0: return G_HIZ;
      1: return G_REC;
      2: return 6'h38;
      default: return 6'h07;
    endcase
  endfunction

  initial begin
    rst = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hf;
    level_req = 10'h000;
    drive_hs = 3'h1;
    drive_ls = 3'h4;
    hs_modulation = 1'h1;
    fails = 0;
    checks = 0;
    cycles = 0;
    wait_cyc(2);
    rst <= 1'h0;
    wait_cyc(3);
    rd_check(ADDR_CONFIG, 32'h0, "config after reset");
    rd_check(ADDR_STATUS, 32'h08, "status after reset");
    apb(8'h40, 1'h0, 32'h0, rd, err);
    check({31'h0, err}, 32'h1, "unmapped address error");
    outs({G_RUN, 2'h3}, "idle outputs");
    $display("test reset done");
    for (int i = 0; i < 3; i++) begin
      fault_case(i, {G_HIZ, 2'h1}, {G_RUN, 2'h3}, ADDR_STATUS,
                 (i < 2) ? 32'h24 : 32'h04);
    end
    $display("test supply undervoltage done");
    fault_case(3, {G_HIZ, 2'h2}, {G_RUN, 2'h3}, ADDR_DRIVER_FLAGS,
               32'h1);
    rd_check(ADDR_DRIVER_FLAGS, 32'h1, "flag stays set");
    clear_all();
    rd_check(ADDR_DRIVER_FLAGS, 32'h0, "flag cleared");
    $display("test pump undervoltage done");
    fault_case(4, {G_RUN, 2'h3}, {G_RUN, 2'h3}, ADDR_DRIVER_FLAGS,
               32'h0);
    wr(ADDR_CONFIG, 32'h1);
    fault_case(4, {G_HIZ, 2'h2}, {G_RUN, 2'h3}, ADDR_DRIVER_FLAGS,
               32'h2);
    clear_all();
    $display("test overvoltage done");
    for (int p = 0; p < 4; p++) begin
      wr(ADDR_CONFIG, 32'(p) << 1);
      fault_case(5, (p < 2) ? {G_HIZ, 2'h2} : {G_RUN, 2'h3},
                 (p == 0) ? {G_HIZ, 2'h2} : {G_RUN, 2'h3},
                 ADDR_DRIVER_FLAGS, (p < 3) ? 32'h4 : 32'h0);
      clear_all();
      outs({G_RUN, 2'h3}, "after clear");
    end
    $display("test phase overcurrent done");
    wr(ADDR_CONFIG, 32'h0);
    fault_case(6, {G_HIZ, 2'h1}, {G_RUN, 2'h3}, ADDR_STATUS,
               32'h04);
    $display("test regulator overcurrent done");
    for (int m = 0; m < 10; m++) begin
      wr(ADDR_CONFIG, 32'(m) << 3);
      fault_case(7 + m % 3,
                 (m < 8) ? {stall_gates(m), 2'h2} : {G_RUN, 2'h3},
                 (m < 4) ? {stall_gates(m), 2'h2} : {G_RUN, 2'h3},
                 ADDR_CONTROL_FLAGS,
                 (m < 9) ? (32'h1 | (32'h2 << (m % 3))) : 32'h0);
      clear_all();
      outs({G_RUN, 2'h3}, "stall cleared");
    end
    $display("test stall policies done");
    wr(ADDR_CONFIG, 32'h08);
    level_req[7] <= 1'h1;
    wait_cyc(8);
    outs({G_REC, 2'h2}, "recirculating");
    wait_cyc(RECIRC_DECAY_CYCLES - 10);
    outs({G_REC, 2'h2}, "still recirculating");
    wait_cyc(20);
    outs({G_HIZ, 2'h2}, "decayed to off");
    level_req[7] <= 1'h0;
    // Let the released level clear the synchroniser, or the clear loses.
    wait_cyc(5);
    clear_all();
    $display("test recirculation done");
    wr(ADDR_CONFIG, 32'h18);
    level_req <= 10'h208;
    wait_cyc(10);
    outs({G_HIZ, 2'h2}, "most restrictive");
    level_req <= 10'h200;
    wait_cyc(10);
    outs({6'h07, 2'h2}, "latched brake holds pin");
    level_req <= 10'h000;
    wait_cyc(5);
    clear_all();
    outs({G_RUN, 2'h3}, "all released");
    $display("test combined faults done");
    wrap_up();
  end
endmodule
